// File: rtl/three_wire_serial_channel.sv
// Three-wire clocked serial channel with its APB register slave.
//
// Overview of operation
// - Mode/control register at index FF60, eight bits, resets to zero.
// - Clock select: 0x external pin, 10 timer output, 11 prescaler.
// - Mode bit 4 low gives three-wire mode; bit 2 picks MSB or LSB first.
// - Mode bits 4,3 at 10 or 11 are other modes; no three-wire transfer then.
// - Wake bit low raises the flag per transfer; high keeps the flag from setting.
// - Enable bit 7 low stops the channel, high lets it run.
// - Bus control register at index FF61 resets to zero.
// - Release trigger sets the output latch high, then clears itself.
// - Command trigger sets the output latch low, then clears itself.
// - Both triggers are forced low while the channel is disabled.
// - Bytes move eight bits, one per serial clock period.
// - Shift on rising clock edge; latch loads on falling edge and drives the serial output.
// - Serial input is captured on rising clock edge.
// - After the eighth bit the shifter stops and the flag sets if the wake bit is low.
// - Idle internal clock pin level follows the port latch.
// - Serial input pin may serve as a plain input port.
// - Bit order is chosen by reversing bus access; shifting never changes.
// - Shift register write starts a transfer when enabled and clock ready.
// - Enabling after the shift register write starts nothing.
`timescale 1ns/1ps
`default_nettype none

module three_wire_serial_channel (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [three_wire_serial_channel_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Serial pins.
	input wire logic serial_clock_pin_in,
	output logic serial_clock_pin_out,
	output logic serial_clock_pin_oe,
	output logic serial_out_line,
	input wire logic serial_in_line,
	// On-chip clock sources and port latch.
	input wire logic eight_bit_timer_output,
	input wire logic [3:0] timer_clock_selector,
	input wire logic clock_port_latch,
	// Flag and plain port view of the serial input.
	output logic channel_irq_flag,
	output logic input_port_pin
);
	import three_wire_serial_channel_pkg::*;

	// Reverses a byte when LSB-first order is chosen.
	function automatic logic [7:0] reorder(input logic [7:0] d, input logic lsb_first);
		logic [7:0] r;
		r = d;
		for (int i = 0; i < BYTE_W; i++) begin
			if (lsb_first) begin
				r[i] = d[BYTE_W-1-i];
			end
		end
		return r;
	endfunction

	serial_mode_control_s mode_reg, mode_next;
	serial_bus_control_s busctl_reg, busctl_next;
	xfer_state_e state_reg, state_next;
	logic [7:0] shift_reg, shift_next;
	logic [2:0] bit_cnt_reg, bit_cnt_next;
	logic [PRESCALE_W-1:0] div_cnt_reg;
	logic [PRESCALE_W-1:0] pre_mask;
	logic sck_s1_reg, sck_s2_reg, sck_s3_reg;
	logic si_s1_reg, si_s2_reg;
	logic tm_d_reg;
	logic so_reg, so_next;
	logic sck_out_next, sck_oe_next;
	logic irq_next;
	logic [31:0] rd_data;
	logic setup, access_done, wr_done, hit;
	logic wr_mode, wr_busctl, wr_shift, wr_status;
	logic three_wire, active, external, busy;
	logic pre_tick, tm_tick, int_tick, ext_fall, ext_rise, fall_ev, rise_ev;
	logic start, done;

	// APB phases; a write takes effect only at the edge where the access completes.
	assign setup = psel & ~penable;
	assign access_done = psel & penable & pready;
	assign wr_done = access_done & pwrite;
	assign wr_mode = wr_done & (paddr == ADDR_MODE);
	assign wr_busctl = wr_done & (paddr == ADDR_BUSCTL);
	assign wr_shift = wr_done & (paddr == ADDR_SHIFT);
	assign wr_status = wr_done & (paddr == ADDR_STATUS);
	assign hit = (paddr == ADDR_MODE) | (paddr == ADDR_BUSCTL) | (paddr == ADDR_SHIFT) | (paddr == ADDR_STATUS);

	// Read mux; the shift register is seen through the bit-order reversal.
	always_comb begin
		rd_data = 32'h0000_0000;
		case (paddr)
			ADDR_MODE: rd_data[7:0] = mode_reg;
			ADDR_BUSCTL: rd_data[7:0] = busctl_reg;
			ADDR_SHIFT: rd_data[7:0] = reorder(shift_reg, mode_reg.first_bit_select);
			ADDR_STATUS: begin
				rd_data[STAT_IRQ_BIT] = channel_irq_flag;
				rd_data[STAT_BUSY_BIT] = busy;
			end
			default: rd_data = 32'h0000_0000;
		endcase
	end

	// No wait state: read data and the answer are registered in the setup cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			prdata <= setup ? rd_data : prdata;
			pslverr <= setup & ~hit;
		end
	end

	// Mode decode.
	assign three_wire = ~mode_reg.mode_select_hi;
	assign active = mode_reg.channel_enable & three_wire;
	assign external = ~mode_reg.clock_select_hi;
	assign busy = (state_reg != ST_IDLE);

	// Clock pin and serial input pass two flip-flops; a third one feeds the edge detector.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck_s1_reg <= 1'b1;
			sck_s2_reg <= 1'b1;
			sck_s3_reg <= 1'b1;
			si_s1_reg <= 1'b0;
			si_s2_reg <= 1'b0;
			tm_d_reg <= 1'b0;
			div_cnt_reg <= '0;
		end else begin
			sck_s1_reg <= serial_clock_pin_in;
			sck_s2_reg <= sck_s1_reg;
			sck_s3_reg <= sck_s2_reg;
			si_s1_reg <= serial_in_line;
			si_s2_reg <= si_s1_reg;
			tm_d_reg <= eight_bit_timer_output;
			div_cnt_reg <= div_cnt_reg + 1'b1;
		end
	end

	// Internal clock sources: each tick is one half period of the shift clock.
	assign pre_mask = {PRESCALE_W{1'b1}} >> (PRESCALE_W - 1 - 32'(timer_clock_selector));
	assign pre_tick = ((div_cnt_reg & pre_mask) == pre_mask);
	assign tm_tick = eight_bit_timer_output & ~tm_d_reg;
	assign int_tick = mode_reg.clock_select_lo ? pre_tick : tm_tick;
	assign ext_fall = sck_s3_reg & ~sck_s2_reg;
	assign ext_rise = ~sck_s3_reg & sck_s2_reg;
	assign fall_ev = external ? ext_fall : int_tick;
	assign rise_ev = external ? ext_rise : int_tick;

	// A write starts a byte only if the channel is already on; enabling later does not.
	assign start = wr_shift & active & ~busy & (~external | sck_s2_reg);
	assign done = (state_reg == ST_LOW) & rise_ev & (bit_cnt_reg == LAST_BIT);

	// Transfer sequencer: falling edge drives out, rising edge samples in.
	always_comb begin
		state_next = state_reg;
		bit_cnt_next = bit_cnt_reg;
		shift_next = shift_reg;
		if (wr_shift & ~busy) begin
			shift_next = reorder(pwdata[7:0], mode_reg.first_bit_select);
		end
		case (state_reg)
			ST_IDLE: begin
				if (start) begin
					state_next = ST_HIGH;
					bit_cnt_next = FIRST_BIT;
				end
			end
			ST_HIGH: begin
				if (fall_ev) begin
					state_next = ST_LOW;
				end
			end
			ST_LOW: begin
				if (rise_ev) begin
					shift_next = {shift_reg[BYTE_W-2:0], si_s2_reg};
					bit_cnt_next = bit_cnt_reg + 1'b1;
					state_next = (bit_cnt_reg == LAST_BIT) ? ST_IDLE : ST_HIGH;
				end
			end
			default: state_next = ST_IDLE;
		endcase
		if (!active) begin
			state_next = ST_IDLE;
		end
	end

	// Clock pin drive: high between pulses, port latch when idle, only in internal mode.
	assign sck_out_next = (state_next == ST_IDLE) ? clock_port_latch : (state_next == ST_HIGH);
	assign sck_oe_next = active & ~external;

	// Register writes; bit 6 has no write path and the triggers die with the enable.
	always_comb begin
		mode_next = mode_reg;
		busctl_next = busctl_reg;
		if (wr_mode) begin
			mode_next = pwdata[7:0] & MODE_WMASK;
		end
		if (busctl_reg.release_trigger | busctl_reg.command_trigger) begin
			busctl_next.release_trigger = 1'b0;
			busctl_next.command_trigger = 1'b0;
		end
		if (wr_busctl) begin
			busctl_next = pwdata[7:0];
		end
		if (!mode_next.channel_enable) begin
			busctl_next.release_trigger = 1'b0;
			busctl_next.command_trigger = 1'b0;
		end
	end

	// Output latch: triggers act a cycle after the write; otherwise it follows the falling edge.
	always_comb begin
		so_next = so_reg;
		if (busctl_reg.release_trigger) begin
			so_next = 1'b1;
		end else if (busctl_reg.command_trigger) begin
			so_next = 1'b0;
		end else if ((state_reg == ST_HIGH) & fall_ev & active) begin
			so_next = shift_reg[BYTE_W-1];
		end
	end

	// Completion flag; a completion in the clearing cycle still sets it.
	assign irq_next = (done & ~mode_reg.wake_on_address) |
		(channel_irq_flag & ~(wr_status & pwdata[STAT_IRQ_BIT]));

	// State registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_reg <= MODE_RESET;
			busctl_reg <= BUSCTL_RESET;
			state_reg <= ST_IDLE;
			bit_cnt_reg <= FIRST_BIT;
			shift_reg <= SHIFT_RESET;
			so_reg <= 1'b0;
			channel_irq_flag <= 1'b0;
			serial_clock_pin_out <= 1'b1;
			serial_clock_pin_oe <= 1'b0;
			input_port_pin <= 1'b0;
		end else begin
			mode_reg <= mode_next;
			busctl_reg <= busctl_next;
			state_reg <= state_next;
			bit_cnt_reg <= bit_cnt_next;
			shift_reg <= shift_next;
			so_reg <= so_next;
			channel_irq_flag <= irq_next;
			serial_clock_pin_out <= sck_out_next;
			serial_clock_pin_oe <= sck_oe_next;
			input_port_pin <= si_s2_reg;
		end
	end

	assign serial_out_line = so_reg;

	// Checks on the channel behaviour.
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_bit6_zero;
		mode_reg.readonly_status_bit6 == 1'b0;
	endproperty
	a_bit6_zero: assert property (p_bit6_zero) else $error("read-only bit 6 changed");

	property p_release;
		busctl_reg.release_trigger |=> serial_out_line && !busctl_reg.release_trigger;
	endproperty
	a_release: assert property (p_release) else $error("release trigger did not set latch");

	property p_command;
		busctl_reg.command_trigger && !busctl_reg.release_trigger |=> !serial_out_line && !busctl_reg.command_trigger;
	endproperty
	a_command: assert property (p_command) else $error("command trigger did not clear latch");

	property p_trig_off;
		!mode_reg.channel_enable |-> !busctl_reg.release_trigger && !busctl_reg.command_trigger;
	endproperty
	a_trig_off: assert property (p_trig_off) else $error("trigger set while disabled");

	property p_stop;
		!active |=> state_reg == ST_IDLE;
	endproperty
	a_stop: assert property (p_stop) else $error("transfer ran while stopped");

	property p_done_flag;
		done && !mode_reg.wake_on_address |=> channel_irq_flag && state_reg == ST_IDLE;
	endproperty
	a_done_flag: assert property (p_done_flag) else $error("flag missing after eighth bit");

	property p_wake_quiet;
		mode_reg.wake_on_address && !channel_irq_flag |=> !channel_irq_flag;
	endproperty
	a_wake_quiet: assert property (p_wake_quiet) else $error("flag set with wake bit high");

	property p_capture;
		state_reg == ST_LOW && rise_ev && active |=> shift_reg[0] == $past(si_s2_reg);
	endproperty
	a_capture: assert property (p_capture) else $error("input bit not captured");

	property p_start;
		start |=> state_reg == ST_HIGH && bit_cnt_reg == FIRST_BIT && serial_clock_pin_out;
	endproperty
	a_start: assert property (p_start) else $error("write did not start transfer");

	property p_idle_pin;
		state_reg == ST_IDLE && !start |=> serial_clock_pin_out == $past(clock_port_latch);
	endproperty
	a_idle_pin: assert property (p_idle_pin) else $error("idle clock pin not following latch");

	property p_clock_release;
		!active |=> !serial_clock_pin_oe;
	endproperty
	a_clock_release: assert property (p_clock_release) else $error("clock pin driven while stopped");

	// The latch may only move on a falling clock edge or a trigger, never while the clock is low.
	property p_out_hold;
		state_reg == ST_LOW && !busctl_reg.release_trigger && !busctl_reg.command_trigger |=> $stable(serial_out_line);
	endproperty
	a_out_hold: assert property (p_out_hold) else $error("serial output moved between falling edges");

endmodule // three_wire_serial_channel

`default_nettype wire

// File: rtl/three_wire_serial_channel_pkg.sv
// Constants, register layouts and state codes of the three-wire serial channel.
package three_wire_serial_channel_pkg;

	// Register indices; each register takes one aligned word at four times its index.
	localparam int unsigned ADDR_W = 18;
	localparam logic [15:0] IDX_MODE = 16'hff60;
	localparam logic [15:0] IDX_BUSCTL = 16'hff61;
	localparam logic [15:0] IDX_SHIFT = 16'hff62;
	localparam logic [15:0] IDX_STATUS = 16'hff63;
	localparam logic [ADDR_W-1:0] ADDR_MODE = {IDX_MODE, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_BUSCTL = {IDX_BUSCTL, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_SHIFT = {IDX_SHIFT, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS, 2'b00};

	// Reset values and write masks.
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] BUSCTL_RESET = 8'h00;
	localparam logic [7:0] SHIFT_RESET = 8'h00;
	localparam logic [7:0] MODE_WMASK = 8'hbf;

	// Status word bit positions.
	localparam int unsigned STAT_IRQ_BIT = 0;
	localparam int unsigned STAT_BUSY_BIT = 1;

	// Transfer length and prescaler width.
	localparam int unsigned BYTE_W = 8;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [2:0] FIRST_BIT = 3'h0;
	localparam int unsigned PRESCALE_W = 16;

	// Mode/control register layout.
	typedef struct packed {
		logic channel_enable;
		logic readonly_status_bit6;
		logic wake_on_address;
		logic mode_select_hi;
		logic mode_select_mid;
		logic first_bit_select;
		logic clock_select_hi;
		logic clock_select_lo;
	} serial_mode_control_s;

	// Bus control register layout; the upper bits belong to other modes and only store.
	typedef struct packed {
		logic [5:0] other_bits;
		logic command_trigger;
		logic release_trigger;
	} serial_bus_control_s;

	// Transfer sequencer states.
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_HIGH = 3'b010,
		ST_LOW = 3'b100
	} xfer_state_e;

endpackage

// File: test/serial_peripheral_model.sv
// Behavioural model of the peripheral on the far side of the serial link.
`timescale 1ns/1ps
`default_nettype none
module serial_peripheral_model (
	// Shared clock line and data lines.
	input wire logic sck,
	input wire logic so,
	output logic si,
	// Clock drive used when the channel takes its clock from outside.
	output logic ext_clk
);
	logic [7:0] tx;
	logic [7:0] rx;
	int idx;
	int pulses;

	// The clock line stands high between frames.
	initial begin
		tx = 8'h00;
		rx = 8'h00;
		idx = 8;
		pulses = 0;
		si = 1'b1;
		ext_clk = 1'b1;
	end

	// Arms a new frame; the byte leaves most significant bit first.
	task automatic load(input logic [7:0] d);
		tx = d;
		rx = 8'h00;
		idx = 0;
		pulses = 0;
	endtask

	// Eight pulses of the external clock, then the line stands high.
	task automatic ext_frame(input int half);
		repeat (8) begin
			ext_clk = 1'b0;
			#half;
			ext_clk = 1'b1;
			#half;
		end
	endtask

	// Next bit goes out on the falling clock edge.
	always @(negedge sck) begin
		if (idx < 8) si = tx[3'(7 - idx)];
	end

	// Data is taken on the rising edge; once the hold time runs out the line shows the inverse.
	always @(posedge sck) begin
		pulses = pulses + 1;
		if (idx < 8) begin
			rx = {rx[6:0], so};
			idx = idx + 1;
			if (idx == 8) si <= #20 ~si;
		end
	end
endmodule // serial_peripheral_model
`default_nettype wire

// File: test/three_wire_serial_channel_tb_top.sv
// Self-checking testbench of the three-wire serial channel.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin n_fail++; $display("CHECK FAILED %s exp %h got %h", nm, ex, gt); end end
module three_wire_serial_channel_tb_top;
	import three_wire_serial_channel_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic sck_out, sck_oe, so, si, tmr, port_latch, flag, port_pin, ext_clk;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [3:0] tcs;
	int n_fail, num_checks;
	int cyc = 0;
	wire logic sck = sck_oe ? sck_out : ext_clk;

	three_wire_serial_channel three_wire_serial_channel_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .serial_clock_pin_in(sck), .serial_clock_pin_out(sck_out), .serial_clock_pin_oe(sck_oe),
		.serial_out_line(so), .serial_in_line(si), .eight_bit_timer_output(tmr), .timer_clock_selector(tcs),
		.clock_port_latch(port_latch), .channel_irq_flag(flag), .input_port_pin(port_pin));
	serial_peripheral_model serial_peripheral_model_inst (.sck(sck), .so(so), .si(si), .ext_clk(ext_clk));

	// Clock generator.
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	// Timer output toggles every four cycles, so its rising edges are eight cycles apart; also the hang limit.
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		tmr <= cyc[2];
		if (cyc == 30000) begin
			n_fail++;
			finish_test();
		end
	end

	// One APB transfer; the request stands until the rising edge that sees pready, where the answer is taken.
	// Only the bench's cycle limit ends a wait that never gets an answer.
	task automatic xfer(input logic [ADDR_W-1:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a);
		xfer(a, 1'b0, 32'h0000_0000);
	endtask

	// Polls the status word until the shifter is idle.
	task automatic wait_idle;
		do begin
			rd(ADDR_STATUS);
		end while (r[STAT_BUSY_BIT] !== 1'b0);
	endtask

	function automatic logic [7:0] rev8(input logic [7:0] v);
		logic [7:0] o;
		for (int i = 0; i < 8; i++) o[i] = v[7 - i];
		return o;
	endfunction

	// One whole byte exchange under mode m; the flag is cleared afterwards.
	task automatic frame(input logic [7:0] m, input logic [7:0] d, input logic [7:0] p);
		serial_peripheral_model_inst.load(p);
		xfer(ADDR_MODE, 1'b1, {24'h00_0000, m});
		xfer(ADDR_SHIFT, 1'b1, {24'h00_0000, d});
		// The outside clock moves on falling edges of pclk so the synchroniser never races it.
		if (m[1] == 1'b0) begin
			@(negedge pclk);
			serial_peripheral_model_inst.ext_frame(40);
		end
		wait_idle();
		`CHK("sent", m[2] ? rev8(d) : d, serial_peripheral_model_inst.rx)
		`CHK("pulses", 8, serial_peripheral_model_inst.pulses)
		rd(ADDR_SHIFT);
		`CHK("received", {24'h00_0000, m[2] ? rev8(p) : p}, r)
		`CHK("flag", ~m[5], flag)
		xfer(ADDR_STATUS, 1'b1, 32'h0000_0001);
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// Main sequence.
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		tcs = 4'h2;
		port_latch = 1'b1;
		n_fail = 0;
		num_checks = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values, a refused address and the read-only bit.
		rd(ADDR_MODE);
		`CHK("mode reset", 32'h0000_0000, r)
		rd(ADDR_BUSCTL);
		`CHK("busctl reset", 32'h0000_0000, r)
		rd('0);
		`CHK("unmapped", 1'b1, e)
		xfer(ADDR_MODE, 1'b1, 32'h0000_00ff);
		rd(ADDR_MODE);
		`CHK("mode bit6", 32'h0000_00bf, r)
		// Triggers move the output latch while enabled and idle.
		xfer(ADDR_MODE, 1'b1, 32'h0000_0083);
		xfer(ADDR_BUSCTL, 1'b1, 32'h0000_0001);
		repeat (2) @(negedge pclk);
		`CHK("latch high", 1'b1, so)
		rd(ADDR_BUSCTL);
		`CHK("release self clear", 32'h0000_0000, r)
		xfer(ADDR_BUSCTL, 1'b1, 32'h0000_0002);
		repeat (2) @(negedge pclk);
		`CHK("latch low", 1'b0, so)
		xfer(ADDR_MODE, 1'b1, 32'h0000_0000);
		xfer(ADDR_BUSCTL, 1'b1, 32'h0000_0001);
		repeat (2) @(negedge pclk);
		`CHK("latch disabled", 1'b0, so)
		// Every clock source, two prescaler settings and both bit orders; the wake bit stays low in this mode.
		frame(8'h83, 8'ha5, 8'h61);
		tcs <= 4'h1;
		frame(8'h87, 8'h13, 8'h61);
		frame(8'h82, 8'h3c, 8'h96);
		frame(8'h80, 8'hc7, 8'h0f);
		frame(8'h86, 8'h5a, 8'h33);
		// The idle internal clock follows the port latch.
		xfer(ADDR_MODE, 1'b1, 32'h0000_0083);
		@(posedge pclk);
		port_latch <= 1'b0;
		repeat (3) @(negedge pclk);
		`CHK("idle clock", 1'b0, sck)
		`CHK("port pin", si, port_pin)
		@(posedge pclk);
		port_latch <= 1'b1;
		// Mode bits 4,3 at 10 with the wake bit set, and a late enable, start nothing; arm the model once the clock pin is high again.
		xfer(ADDR_MODE, 1'b1, 32'h0000_00b3);
		serial_peripheral_model_inst.load(8'h00);
		xfer(ADDR_SHIFT, 1'b1, 32'h0000_0055);
		rd(ADDR_STATUS);
		`CHK("other mode idle", 32'h0000_0000, r)
		xfer(ADDR_MODE, 1'b1, 32'h0000_0003);
		xfer(ADDR_SHIFT, 1'b1, 32'h0000_0055);
		xfer(ADDR_MODE, 1'b1, 32'h0000_0083);
		repeat (40) @(negedge pclk);
		rd(ADDR_STATUS);
		`CHK("late enable idle", 32'h0000_0000, r)
		`CHK("no pulses", 0, serial_peripheral_model_inst.pulses)
		finish_test();
	end
endmodule // three_wire_serial_channel_tb_top
`default_nettype wire
